// file: memory_map_pkg.sv
// Package holding the memory map constants, size setting codes and register offsets.
package memory_map_pkg;

    // ----------------------------------------------------------------
    // Address space and flash organisation
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int BLOCK_SHIFT = 10;
    localparam logic [15:0] VECTOR_LAST = 16'h003F;
    localparam logic [15:0] OPTION_FIRST = 16'h0080;
    localparam logic [15:0] OPTION_LAST = 16'h0084;
    localparam logic [15:0] SECURITY_ID_FIRST = 16'h0085;
    localparam logic [15:0] SECURITY_ID_LAST = 16'h008E;
    localparam logic [15:0] CLUSTER_SIZE = 16'h1000;
    localparam logic [15:0] BOOT_CLUSTER0_LAST = 16'h0FFF;
    localparam logic [15:0] CONVERTER_REG_LO = 16'hFA26;
    localparam logic [15:0] CONVERTER_REG_HI = 16'hFA27;
    localparam logic [15:0] CONVERTER_HOLE_FIRST = 16'hFA20;
    localparam logic [15:0] CONVERTER_HOLE_LAST = 16'hFA2F;

    // ----------------------------------------------------------------
    // Size setting codes and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MEMORY_SIZE_RESET = 8'hCF;
    localparam logic [7:0] EXPANSION_SIZE_RESET = 8'h0C;
    localparam logic [7:0] MEMORY_SIZE_16K = 8'h04;
    localparam logic [7:0] MEMORY_SIZE_24K = 8'hC6;
    localparam logic [7:0] MEMORY_SIZE_32K = 8'hC8;
    localparam logic [7:0] MEMORY_SIZE_48K = 8'hCC;
    localparam logic [7:0] MEMORY_SIZE_60K = 8'hCF;
    localparam logic [7:0] EXPANSION_NONE = 8'h0C;
    localparam logic [7:0] EXPANSION_1K = 8'h0A;
    localparam logic [15:0] ROM_END_16K = 16'h3FFF;
    localparam logic [15:0] ROM_END_24K = 16'h5FFF;
    localparam logic [15:0] ROM_END_32K = 16'h7FFF;
    localparam logic [15:0] ROM_END_48K = 16'hBFFF;
    localparam logic [15:0] ROM_END_60K = 16'hEFFF;
    localparam logic [15:0] HSRAM_END = 16'hFEFF;
    localparam logic [15:0] HSRAM_FIRST_768 = 16'hFC00;
    localparam logic [15:0] HSRAM_FIRST_1K = 16'hFB00;
    localparam logic [15:0] EXPRAM_FIRST = 16'hF000;
    localparam logic [15:0] EXPRAM_LAST = 16'hF3FF;
    localparam logic [15:0] SFR_FIRST = 16'hFF00;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_MEMORY_SIZE = 8'h00;
    localparam logic [7:0] REG_EXPANSION_SIZE = 8'h04;
    localparam logic [7:0] REG_SECURITY = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int SEC_BLOCK_BIT = 0;
    localparam int SEC_SWAP_BIT = 1;
    localparam int SEC_SIGMA_BIT = 2;

    // Region codes reported for the decoded address.
    typedef enum logic [2:0] {
        REGION_NONE,
        REGION_ROM,
        REGION_HSRAM,
        REGION_EXPRAM,
        REGION_SFR,
        REGION_CONVERTER
    } region_e;

endpackage : memory_map_pkg

// file: memory_space_size_config.sv
// Memory space decoder with size settings, boot swap mapping and cluster 0 write guard.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
module memory_space_size_config (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic vector_fetch,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr,
    output logic [2:0] region,
    output logic [5:0] flash_block,
    output logic in_vector_table,
    output logic write_allowed,
    output logic write_refused,
    output logic [15:0] vector_value,
    output logic vector_valid
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Last ROM address for a memory size code; unknown codes fall back to the 60 KB map.
    function automatic logic [15:0] rom_end(input logic [7:0] code);
        logic [15:0] result;
        result = memory_map_pkg::ROM_END_60K;
        if (code == memory_map_pkg::MEMORY_SIZE_16K) begin
            result = memory_map_pkg::ROM_END_16K;
        end else if (code == memory_map_pkg::MEMORY_SIZE_24K) begin
            result = memory_map_pkg::ROM_END_24K;
        end else if (code == memory_map_pkg::MEMORY_SIZE_32K) begin
            result = memory_map_pkg::ROM_END_32K;
        end else if (code == memory_map_pkg::MEMORY_SIZE_48K) begin
            result = memory_map_pkg::ROM_END_48K;
        end
        return result;
    endfunction : rom_end

    // True when an address falls inside an inclusive range.
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] memory_size_select;
    logic [7:0] expansion_ram_size_select;
    logic [2:0] security;
    logic wb_ack_q;
    logic [31:0] rdata_q;
    logic [7:0] next_memory_size_select;
    logic [7:0] next_expansion_ram_size_select;
    logic [2:0] next_security;
    logic next_ack;
    logic [31:0] next_rdata;
    logic bus_req;
    logic [7:0] reg_off;
    logic write_refused_sticky;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign reg_off = wb_adr_i[7:0];

    // Bus slave next state; one wait state keeps the read data registered.
    always_comb begin
        next_memory_size_select = memory_size_select;
        next_expansion_ram_size_select = expansion_ram_size_select;
        next_security = security;
        next_ack = bus_req;
        next_rdata = 32'h0000_0000;
        if (bus_req && wb_we_i && wb_sel_i[0]) begin
            if (reg_off == memory_map_pkg::REG_MEMORY_SIZE) begin
                next_memory_size_select = wb_dat_i[7:0];
            end else if (reg_off == memory_map_pkg::REG_EXPANSION_SIZE) begin
                next_expansion_ram_size_select = wb_dat_i[7:0];
            end else if (reg_off == memory_map_pkg::REG_SECURITY) begin
                next_security = wb_dat_i[2:0];
            end
        end
        if (bus_req && !wb_we_i) begin
            if (reg_off == memory_map_pkg::REG_MEMORY_SIZE) begin
                next_rdata = {24'h00_0000, memory_size_select};
            end else if (reg_off == memory_map_pkg::REG_EXPANSION_SIZE) begin
                next_rdata = {24'h00_0000, expansion_ram_size_select};
            end else if (reg_off == memory_map_pkg::REG_SECURITY) begin
                next_rdata = {29'h0000_0000, security};
            end else if (reg_off == memory_map_pkg::REG_STATUS) begin
                next_rdata = {4'h0, write_refused_sticky, vector_valid, in_vector_table,
                              region, flash_block, mem_addr};
            end
        end
    end

    // Register the bus state; unmapped addresses ack and read zero.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            memory_size_select <= memory_map_pkg::MEMORY_SIZE_RESET;
            expansion_ram_size_select <= memory_map_pkg::EXPANSION_SIZE_RESET;
            security <= 3'h0;
            wb_ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            memory_size_select <= next_memory_size_select;
            expansion_ram_size_select <= next_expansion_ram_size_select;
            security <= next_security;
            wb_ack_q <= next_ack;
            rdata_q <= next_rdata;
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = rdata_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [15:0] next_mem_addr;
    logic [2:0] next_region;
    logic [5:0] next_block;
    logic next_in_vector;
    logic next_allowed;
    logic next_refused;
    logic boot_block_area;
    logic [15:0] hsram_first;
    logic expansion_on;

    // The full 16-bit address is always decoded; addresses outside every enabled region report REGION_NONE.
    always_comb begin
        boot_block_area = 1'b0;
        expansion_on = (expansion_ram_size_select == memory_map_pkg::EXPANSION_1K);
        hsram_first = (memory_size_select == memory_map_pkg::MEMORY_SIZE_16K) ?
                      memory_map_pkg::HSRAM_FIRST_768 : memory_map_pkg::HSRAM_FIRST_1K;
        next_mem_addr = cpu_addr;
        // option byte copy in the other cluster
        if (security[memory_map_pkg::SEC_SWAP_BIT] &&
            in_range(cpu_addr, memory_map_pkg::OPTION_FIRST, memory_map_pkg::OPTION_LAST)) begin
            next_mem_addr = cpu_addr + memory_map_pkg::CLUSTER_SIZE;
            boot_block_area = 1'b1;
        end
        // security ID copy in the other cluster
        if (security[memory_map_pkg::SEC_SWAP_BIT] &&
            in_range(cpu_addr, memory_map_pkg::SECURITY_ID_FIRST,
                     memory_map_pkg::SECURITY_ID_LAST)) begin
            next_mem_addr = cpu_addr + memory_map_pkg::CLUSTER_SIZE;
            boot_block_area = 1'b1;
        end
        next_region = memory_map_pkg::REGION_NONE;
        if (cpu_addr <= rom_end(memory_size_select)) begin
            next_region = memory_map_pkg::REGION_ROM;
        end else if (expansion_on && in_range(cpu_addr, memory_map_pkg::EXPRAM_FIRST,
                                              memory_map_pkg::EXPRAM_LAST)) begin
            next_region = memory_map_pkg::REGION_EXPRAM;
        end else if (security[memory_map_pkg::SEC_SIGMA_BIT] &&
                     in_range(cpu_addr, memory_map_pkg::CONVERTER_REG_LO,
                              memory_map_pkg::CONVERTER_REG_HI)) begin
            next_region = memory_map_pkg::REGION_CONVERTER;
        end else if (in_range(cpu_addr, memory_map_pkg::CONVERTER_HOLE_FIRST,
                              memory_map_pkg::CONVERTER_HOLE_LAST) &&
                     security[memory_map_pkg::SEC_SIGMA_BIT]) begin
            next_region = memory_map_pkg::REGION_NONE;
        end else if (in_range(cpu_addr, hsram_first, memory_map_pkg::HSRAM_END)) begin
            next_region = memory_map_pkg::REGION_HSRAM;
        end else if (cpu_addr >= memory_map_pkg::SFR_FIRST) begin
            next_region = memory_map_pkg::REGION_SFR;
        end
        // 1 KB blocks; block is address over 1024
        next_block = 6'(next_mem_addr >> memory_map_pkg::BLOCK_SHIFT);
        next_in_vector = (cpu_addr <= memory_map_pkg::VECTOR_LAST);
        next_refused = cpu_write && security[memory_map_pkg::SEC_BLOCK_BIT] &&
                       (boot_block_area || next_mem_addr <= memory_map_pkg::BOOT_CLUSTER0_LAST);
        next_allowed = cpu_write && !next_refused && (next_region != memory_map_pkg::REGION_NONE);
    end

    // Decoded outputs are registered, so they follow cpu_addr by one cycle.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= 16'h0000;
            region <= 3'h0;
            flash_block <= 6'h00;
            in_vector_table <= 1'b0;
            write_allowed <= 1'b0;
            write_refused <= 1'b0;
        end else begin
            mem_addr <= next_mem_addr;
            region <= next_region;
            flash_block <= next_block;
            in_vector_table <= next_in_vector;
            write_allowed <= next_allowed;
            write_refused <= next_refused;
        end
    end

    // ----------------------------------------------------------------
    // Vector assembly and refused-write history
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        VEC_IDLE,
        VEC_LOW,
        VEC_HIGH
    } vec_state_e;

    vec_state_e vec_state;
    vec_state_e next_vec_state;
    logic [15:0] next_vector_value;
    logic next_vector_valid;
    logic next_sticky;

    // Low byte arrives one cycle after the even address, high byte one cycle after that.
    always_comb begin
        next_vec_state = vec_state;
        next_vector_value = vector_value;
        next_vector_valid = 1'b0;
        // Set beats clear: a refusal in the cycle of a status read is kept.
        next_sticky = write_refused || (write_refused_sticky &&
                      !(bus_req && !wb_we_i && reg_off == memory_map_pkg::REG_STATUS));
        case (vec_state)
            VEC_IDLE: begin
                if (vector_fetch && !cpu_addr[0]) begin
                    next_vec_state = VEC_LOW;
                end
            end
            VEC_LOW: begin
                next_vector_value = {vector_value[15:8], mem_rdata};
                next_vec_state = VEC_HIGH;
            end
            VEC_HIGH: begin
                next_vector_value = {mem_rdata, vector_value[7:0]};
                next_vector_valid = 1'b1;
                next_vec_state = VEC_IDLE;
            end
            default: begin
                next_vec_state = VEC_IDLE;
            end
        endcase
    end

    // Register vector assembly state.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            vec_state <= VEC_IDLE;
            vector_value <= 16'h0000;
            vector_valid <= 1'b0;
            write_refused_sticky <= 1'b0;
        end else begin
            vec_state <= next_vec_state;
            vector_value <= next_vector_value;
            vector_valid <= next_vector_valid;
            write_refused_sticky <= next_sticky;
        end
    end

endmodule : memory_space_size_config

// file: memory_space_size_config_props.sv
// Checker of bus handshake, decode timing and vector assembly at the block ports.
module memory_space_size_config_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic vector_fetch,
    input wire logic [7:0] mem_rdata,
    input wire logic [15:0] mem_addr,
    input wire logic [2:0] region,
    input wire logic [5:0] flash_block,
    input wire logic in_vector_table,
    input wire logic write_allowed,
    input wire logic write_refused,
    input wire logic [15:0] vector_value,
    input wire logic vector_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // The $past(cpu_addr) terms are gated by $past(rstn) so the first edge is quiet.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held too long");
    a_block_number: assert property (flash_block == mem_addr[15:10])
        else $error("block number is not address over 1024");
    a_vector_flag: assert property ($past(rstn) |->
        in_vector_table == ($past(cpu_addr) <= 16'h003F))
        else $error("vector table flag wrong");
    a_linear_map: assert property ($past(rstn) &&
        ($past(cpu_addr) < 16'h0080 || $past(cpu_addr) > 16'h008E) |-> mem_addr == $past(cpu_addr))
        else $error("address outside swap range was moved");
    a_swap_copy: assert property ($past(rstn) && $past(cpu_addr) inside {[16'h0080:16'h008E]} |->
        mem_addr == $past(cpu_addr) || mem_addr == $past(cpu_addr) + 16'h1000)
        else $error("swapped byte maps to a wrong place");
    a_refuse_write: assert property (write_refused |-> $past(cpu_write) && !write_allowed)
        else $error("refusal without a write or with grant");
    a_sfr_top: assert property ($past(rstn) && $past(cpu_addr) >= 16'hFF00 |->
        region == memory_map_pkg::REGION_SFR)
        else $error("top page not decoded");
    a_vector_time: assert property (vector_fetch && !cpu_addr[0] |->
        ##3 (vector_valid && vector_value == {$past(mem_rdata), $past(mem_rdata, 2)}))
        else $error("vector late or bytes swapped");
    a_valid_pulse: assert property (vector_valid |=> !vector_valid)
        else $error("vector valid held too long");
    a_converter_pair: assert property (region == memory_map_pkg::REGION_CONVERTER |->
        mem_addr inside {16'hFA26, 16'hFA27})
        else $error("converter region on a wrong address");
endmodule : memory_space_size_config_props

bind memory_space_size_config memory_space_size_config_props i_memory_space_size_config_props (
    .core_clk, .rstn, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .cpu_addr, .cpu_write, .vector_fetch,
    .mem_rdata, .mem_addr, .region, .flash_block, .in_vector_table, .write_allowed,
    .write_refused, .vector_value, .vector_valid
);

// file: tb.sv
// Self-checking testbench for the memory space size configuration block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_stb_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_ack_o;
    logic [15:0] cpu_addr = 16'h0;
    logic cpu_write = 1'b0;
    logic vector_fetch = 1'b0;
    logic [7:0] mem_rdata = 8'h0;
    logic [15:0] mem_addr;
    logic [2:0] region;
    logic [5:0] flash_block;
    logic in_vector_table, write_allowed, write_refused, vector_valid;
    logic [15:0] vector_value;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    memory_space_size_config i_memory_space_size_config (.core_clk, .rstn, .wb_adr_i, .wb_dat_i,
        .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .cpu_addr, .cpu_write,
        .vector_fetch, .mem_rdata, .mem_addr, .region, .flash_block, .in_vector_table,
        .write_allowed, .write_refused, .vector_value, .vector_valid);
    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #50 core_clk = ~core_clk;
    // A hang in a bus wait is cut short here; the run needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One classic cycle; the answer latency is taken from the acknowledge, never assumed.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= {24'h00_0000, adr};
        wb_dat_i <= {24'h00_0000, dat};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    // Presents one CPU address and waits until its decode has landed.
    task automatic dec(input logic [15:0] a, input logic w);
        @(posedge core_clk);
        cpu_addr <= a;
        cpu_write <= w;
        @(posedge core_clk);
        #1;
    endtask : dec
    task automatic t_reset();
        wb(1'b0, memory_map_pkg::REG_MEMORY_SIZE, 8'h0);
        check("size reset", rd, 32'h0000_00CF);
        wb(1'b0, memory_map_pkg::REG_EXPANSION_SIZE, 8'h0);
        check("exp reset", rd, 32'h0000_000C);
        wb(1'b1, 8'h10, 8'hFF);
        wb(1'b0, 8'h10, 8'h0);
        check("unmapped", rd, 32'h0);
    endtask : t_reset
    task automatic t_sizes();
        logic [7:0] codes [5] = '{8'h04, 8'hC6, 8'hC8, 8'hCC, 8'hCF};
        logic [15:0] ends [5] = '{16'h3FFF, 16'h5FFF, 16'h7FFF, 16'hBFFF, 16'hEFFF};
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, memory_map_pkg::REG_MEMORY_SIZE, codes[i]);
            wb(1'b0, memory_map_pkg::REG_MEMORY_SIZE, 8'h0);
            check("size back", rd[7:0], codes[i]);
            dec(ends[i], 1'b0);
            check("rom end", region, memory_map_pkg::REGION_ROM);
            dec(ends[i] + 16'h0001, 1'b0);
            check("past rom", region, memory_map_pkg::REGION_NONE);
            dec(16'hFBFF, 1'b0);
            check("ram low", region, i == 0 ? 3'd0 : 3'd2);
        end
        wb(1'b1, memory_map_pkg::REG_EXPANSION_SIZE, 8'h0A);
        dec(16'hF3FF, 1'b0);
        check("exp ram", region, memory_map_pkg::REGION_EXPRAM);
        wb(1'b1, memory_map_pkg::REG_EXPANSION_SIZE, 8'h0C);
        dec(16'hF000, 1'b0);
        check("no exp ram", region, memory_map_pkg::REGION_NONE);
        dec(16'hFF00, 1'b1);
        check("sfr", {region, write_allowed}, {memory_map_pkg::REGION_SFR, 1'b1});
    endtask : t_sizes
    task automatic t_blocks();
        logic [15:0] adrs [5] = '{16'h0000, 16'h03FF, 16'h0400, 16'h7C00, 16'hEFFF};
        logic [5:0] nums [5] = '{6'h00, 6'h00, 6'h01, 6'h1F, 6'h3B};
        for (int i = 0; i < 5; i++) begin
            dec(adrs[i], 1'b0);
            check("block", flash_block, nums[i]);
        end
    endtask : t_blocks
    task automatic t_swap();
        logic [15:0] adrs [6] = '{16'h0080, 16'h0084, 16'h0085, 16'h008E, 16'h008F, 16'h007F};
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h02);
        wb(1'b0, memory_map_pkg::REG_SECURITY, 8'h0);
        check("sec back", rd, 32'h0000_0002);
        for (int i = 0; i < 6; i++) begin
            dec(adrs[i], 1'b0);
            check("swap", mem_addr, adrs[i] + (i < 4 ? 16'h1000 : 16'h0));
        end
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h00);
        dec(16'h0084, 1'b0);
        check("no swap", mem_addr, 16'h0084);
    endtask : t_swap
    task automatic t_guard();
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h01);
        dec(16'h0100, 1'b1);
        check("refused", {write_refused, write_allowed}, 2'b10);
        dec(16'h2000, 1'b1);
        check("granted", {write_refused, write_allowed}, 2'b01);
        dec(16'h0000, 1'b0);
        wb(1'b0, memory_map_pkg::REG_STATUS, 8'h0);
        check("sticky", rd[27], 1'b1);
        check("status", rd, 32'h0A40_0000);
        wb(1'b0, memory_map_pkg::REG_STATUS, 8'h0);
        check("cleared", rd[27], 1'b0);
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h00);
        dec(16'h0100, 1'b1);
        check("open", {write_refused, write_allowed}, 2'b01);
        dec(16'h0000, 1'b0);
    endtask : t_guard
    task automatic t_conv();
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h04);
        dec(16'hFA26, 1'b0);
        check("conv lo", region, memory_map_pkg::REGION_CONVERTER);
        dec(16'hFA27, 1'b0);
        check("conv hi", region, memory_map_pkg::REGION_CONVERTER);
        dec(16'hFA25, 1'b0);
        check("hole", region, memory_map_pkg::REGION_NONE);
        wb(1'b1, memory_map_pkg::REG_SECURITY, 8'h00);
        dec(16'hFA26, 1'b0);
        check("no conv", region, memory_map_pkg::REGION_NONE);
    endtask : t_conv
    task automatic t_vector();
        @(posedge core_clk);
        cpu_addr <= 16'h0004;
        vector_fetch <= 1'b1;
        @(posedge core_clk);
        vector_fetch <= 1'b0;
        mem_rdata <= 8'h34;
        @(posedge core_clk);
        mem_rdata <= 8'hB2;
        for (int i = 0; i < 6 && vector_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check("vector", {vector_valid, vector_value}, 17'h1_B234);
        dec(16'h003F, 1'b0);
        check("table end", in_vector_table, 1'b1);
        dec(16'h0040, 1'b0);
        check("past table", in_vector_table, 1'b0);
    endtask : t_vector
    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_sizes();
        t_blocks();
        t_swap();
        t_guard();
        t_conv();
        t_vector();
        wrap_up();
    end
endmodule : tb
